// ===== rtl/rbc_pkg.sv
/*
  rbc_pkg: constants for the rf bias control output block.
  assumes: imported whole by every rbc rtl module.
*/
package rbc_pkg;
  localparam int CTRL_ADDR_W = 8;
  localparam int DATA_W = 16;
  // modem control register holding the rf interface bits
  localparam logic [7:0] CTRL_B_OFFS = 8'h07;
  // modem activity readback register
  localparam logic [7:0] STAT_OFFS = 8'h08;
  localparam int BIAS_EN_BIT = 14;
  localparam int POL_INV_BIT = 13;
  localparam int PORT_SEL_BIT = 12;
  localparam logic [15:0] CTRL_B_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;

  typedef enum logic [2:0] {
    RBC_IDLE = 3'b000,
    RBC_RX = 3'b001,
    RBC_TX = 3'b010,
    RBC_DOZE = 3'b011,
    RBC_HIBERNATE = 3'b100
  } rbc_radio_state_t;
endpackage : rbc_pkg

// ===== rtl/rbc_level_sel.sv
/*
  rbc_level_sel: combinational choice of the bias pin level and enable.
  assumes: inputs come from registers on mclk_i in the parent.
*/
`timescale 1ns/10ps
`default_nettype none
module rbc_level_sel
  import rbc_pkg::*;
(
  input wire logic bias_out_enable_i,
  input wire logic antenna_port_select_i,
  input wire logic bias_polarity_invert_i,
  input wire rbc_radio_state_t radio_state_i,
  output logic level_o,
  output logic drive_o
);
  always_comb begin
    drive_o = bias_out_enable_i;
    level_o = 1'b0;
    case (radio_state_i)
      RBC_TX: begin
        if (antenna_port_select_i) begin
          level_o = 1'b1;
        end else begin
          level_o = ~bias_polarity_invert_i;
        end
      end
      RBC_RX: begin
        if (antenna_port_select_i) begin
          level_o = 1'b0;
        end else begin
          level_o = bias_polarity_invert_i;
        end
      end
      RBC_IDLE, RBC_DOZE, RBC_HIBERNATE: begin
        level_o = 1'b0;
      end
      default: begin
        level_o = 1'b0;
      end
    endcase
  end
endmodule : rbc_level_sel
`default_nettype wire

// ===== rtl/rbc_bias_out.sv
/*
  rbc_bias_out: rf bias control pin driver with a small register port.
  assumes: radio activity strobes come from modem logic on mclk_i,
  register master follows the one-cycle strobe protocol.
*/
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - drive pin when enabled; mode then activity
// - pin level follows transmit or receive activity
// - single port: high transmit, low receive
// - dual port: inversion flips transmit/receive levels
// - idle, doze, hibernate drive low
// - enable bit 14, reset 0, else tristate
// - port select bit 12, reset 0, dual
// - inversion bit 13, reset 0, dual only
module rbc_bias_out
  import rbc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [CTRL_ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  input wire logic doze_i,
  input wire logic hibernate_i,
  output logic rf_bias_ctrl_out_o,
  output logic rf_bias_ctrl_out_oe_o
);
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] rdata_r;
  rbc_radio_state_t state_r;
  rbc_radio_state_t state_nxt;
  logic level;
  logic drive;
  logic pin_r;
  logic oe_r;

  // only the three rf interface bits are kept; others read as zero
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_B_RST;
    end else if (reg_wr_i && reg_addr_i == CTRL_B_OFFS) begin
      ctrl_r <= CTRL_B_RST;
      ctrl_r[BIAS_EN_BIT] <= reg_wdata_i[BIAS_EN_BIT];
      ctrl_r[POL_INV_BIT] <= reg_wdata_i[POL_INV_BIT];
      ctrl_r[PORT_SEL_BIT] <= reg_wdata_i[PORT_SEL_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_r <= STAT_RST;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        CTRL_B_OFFS: rdata_r <= ctrl_r;
        STAT_OFFS: rdata_r <= {13'h0000, state_r};
        default: rdata_r <= 16'h0000;
      endcase
    end else begin
      rdata_r <= 16'h0000;
    end
  end
  assign reg_rdata_o = rdata_r;

  // transmit wins if both strobes are seen; low power states come next
  always_comb begin
    if (tx_active_i) begin
      state_nxt = RBC_TX;
    end else if (rx_active_i) begin
      state_nxt = RBC_RX;
    end else if (hibernate_i) begin
      state_nxt = RBC_HIBERNATE;
    end else if (doze_i) begin
      state_nxt = RBC_DOZE;
    end else begin
      state_nxt = RBC_IDLE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= RBC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  rbc_level_sel u_sel (
    .bias_out_enable_i(ctrl_r[BIAS_EN_BIT]),
    .antenna_port_select_i(ctrl_r[PORT_SEL_BIT]),
    .bias_polarity_invert_i(ctrl_r[POL_INV_BIT]),
    .radio_state_i(state_r),
    .level_o(level),
    .drive_o(drive)
  );

  // reset gives a tristated pin; the level register is also cleared to low
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      pin_r <= level;
      oe_r <= drive;
    end
  end
  assign rf_bias_ctrl_out_o = pin_r;
  assign rf_bias_ctrl_out_oe_o = oe_r;
endmodule : rbc_bias_out
`default_nettype wire

// ===== bench/rbc_front_end.sv
/* rbc_front_end: board line at the bias pin; assumes pin and enable from rbc_bias_out */
`timescale 1ns/10ps
`default_nettype none
module rbc_front_end (
  input wire logic level_i,
  input wire logic drive_i,
  output logic line_o
);
  assign line_o = drive_i & level_i;
endmodule : rbc_front_end
`default_nettype wire

// ===== bench/rbc_bias_monitor.sv
/* rbc_bias_monitor: pin and readback checks; assumes binding into rbc_bias_out */
`timescale 1ns/10ps
`default_nettype none
module rbc_bias_monitor (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic tx_active_i,
  input wire logic rx_active_i,
  input wire logic rf_bias_ctrl_out_o,
  input wire logic rf_bias_ctrl_out_oe_o
);
  logic [15:0] c;
  logic [4:0] k;
  wire o = rf_bias_ctrl_out_oe_o, p = rf_bias_ctrl_out_o, g = o & k[4:3] == 2'h0;
  // activity reaches the pin two edges late; k hides edges still fed by reset
  always_ff @(posedge mclk_i) k <= {k[3], rst_i, tx_active_i, rx_active_i & !tx_active_i, !tx_active_i & !rx_active_i};
  always_ff @(posedge mclk_i) if (rst_i) c <= 16'h0000;
    else if (reg_wr_i && reg_addr_i == 8'h07) c <= reg_wdata_i & 16'h7000;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  en_gate_a: assert property (!k[3] |-> o == $past(c[14])) else $error("oe");
  oe_hold_a: assert property (!k[3] && !$past(reg_wr_i, 2) |-> $stable(o)) else $error("oe hold");
  single_tx_a: assert property (g && $past(c[12] && k[2]) |-> p) else $error("s tx");
  single_rx_a: assert property (g && $past(c[12] && k[1]) |-> !p) else $error("s rx");
  dual_tx_a: assert property (g && $past(!c[12] && k[2]) |-> p != $past(c[13])) else $error("d tx");
  dual_rx_a: assert property (g && $past(!c[12] && k[1]) |-> p == $past(c[13])) else $error("d rx");
  quiet_low_a: assert property (g && $past(k[0]) |-> !p) else $error("quiet");
  ctl_read_a: assert property (!k[3] && $past(reg_rd_i && reg_addr_i == 8'h07) |-> reg_rdata_o == $past(c)) else $error("rd");
endmodule : rbc_bias_monitor
bind rbc_bias_out rbc_bias_monitor u_mon (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .tx_active_i(tx_active_i),
  .rx_active_i(rx_active_i),
  .rf_bias_ctrl_out_o(rf_bias_ctrl_out_o),
  .rf_bias_ctrl_out_oe_o(rf_bias_ctrl_out_oe_o)
);
`default_nettype wire

// ===== bench/test_rf_bias_control_output.sv
/* test_rf_bias_control_output: random traffic against a bench model; assumes rtl and bench files */
`timescale 1ns/10ps
`default_nettype none
module test_rf_bias_control_output;
  logic mclk_i = 1'h0, rst_i = 1'h1, oe, pin, line;
  logic [31:0] v = 32'h7;
  logic [15:0] rd;
  int mismatches = 0, samples_checked = 0, seed = 27398, ctl = 0, st = 0, ep, er;
  rbc_bias_out u_dut (.mclk_i, .rst_i, .reg_addr_i({4'h0, v[11:8]}), .reg_wdata_i(v[31:16]),
    .reg_wr_i(v[2:0] == 3'h0), .reg_rd_i(v[2:0] == 3'h1), .reg_rdata_o(rd), .tx_active_i(v[20] & v[21]),
    .rx_active_i(v[22]), .doze_i(v[23]), .hibernate_i(v[24]), .rf_bias_ctrl_out_o(pin), .rf_bias_ctrl_out_oe_o(oe));
  rbc_front_end u_fe (.level_i(pin), .drive_i(oe), .line_o(line));
  initial forever #10 mclk_i = ~mclk_i;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) mismatches++;
    if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
  endtask : check
  task automatic conclude;
    $display("%0d checks %0d mismatches", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    #200000 mismatches++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'h0;
    for (int n = 0; n < 4000; n++) begin
      @(posedge mclk_i);
      // a two-cycle reset in mid-run clears the model like the design
      if (rst_i) begin
        ep = 0;
        er = 0;
        ctl = 0;
        st = 0;
      end else begin
        ep = ctl[14] ? 2 + (st == 2 ? ctl[12] | !ctl[13] : st == 1 && !ctl[12] && ctl[13]) : 0;
        er = v[2:0] != 3'h1 ? 0 : v[11:8] == 4'h7 ? ctl : v[11:8] == 4'h8 ? st : 0;
        st = v[20] & v[21] ? 2 : v[22] ? 1 : v[24] ? 4 : v[23] ? 3 : 0;
        if (v[2:0] == 3'h0 && v[11:8] == 4'h7) ctl = v[31:16] & 16'h7000;
      end
      v <= $random(seed);
      rst_i <= (n == 2000 || n == 2001);
      #5 check(16'({oe, oe & line}), 16'(ep));
      check(rd, 16'(er));
    end
    $display("random traffic test done");
    conclude();
  end
endmodule : test_rf_bias_control_output
`default_nettype wire
